// ==== rtl/rsd_datapath.sv ====
// Rotate, subtract, skip, set, swap, table read and XOR datapath.
// Assumes a sequencer that presents one operation per cycle with its
// memory operand already read, and honours skip_taken by discarding
// the next fetched word.
//
// Decided for this implementation: the plain strobed port.
`include "rsd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rsd_datapath #(
  parameter int DATA_W = 8,
  parameter int PAGE_W = 8,
  parameter int PAGE_SEL_W = 8,
  parameter int WORD_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire rsd_pkg::rsd_op_t op_code,
  input wire logic to_acc,
  input wire logic [2:0] bit_sel,
  input wire logic [DATA_W-1:0] mem_operand,
  input wire logic [DATA_W-1:0] imm_value,
  input wire logic [DATA_W-1:0] table_pointer,
  input wire logic [PAGE_SEL_W-1:0] current_page,
  input wire logic [WORD_W-1:0] prog_rdata,
  output logic [PAGE_SEL_W+PAGE_W-1:0] prog_addr,
  output logic mem_we,
  output logic [DATA_W-1:0] mem_wdata,
  output logic [DATA_W-1:0] acc,
  output logic [DATA_W-1:0] table_high_latch,
  output logic carry_flag,
  output logic zero_flag,
  output logic half_carry_flag,
  output logic overflow_flag,
  output logic skip_taken,
  output logic dummy_cycle
);

  // All checks below run on the one system clock and sleep in reset
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] tbh;
    logic c;
    logic z;
    logic hc;
    logic ov;
    logic we;
    logic [DATA_W-1:0] wdata;
    logic skip;
    logic [PAGE_SEL_W+PAGE_W-1:0] paddr;
    rsd_pkg::rsd_state_t st;
  } rsd_state_reg_t;

  rsd_state_reg_t st_reg;
  rsd_state_reg_t st_next;

  // Arithmetic scratch
  logic [DATA_W-1:0] subtrahend;
  logic borrow_in;
  logic [DATA_W:0] diff;
  logic [4:0] low_diff;
  logic [DATA_W-1:0] result;
  logic exec;

  ////////////////////////////////////////////////////////////////////////
  // Subtraction unit, shared by all deduct forms

  always_comb
  begin
    subtrahend = (op_code == rsd_pkg::RSD_OP_DEDUCT_IMM) ?
                 imm_value : mem_operand;
    borrow_in = (op_code == rsd_pkg::RSD_OP_DEDUCT_WITH_BORROW) ?
                ~st_reg.c : 1'b0;
    diff = {1'b0, st_reg.acc} - {1'b0, subtrahend} -
           {{DATA_W{1'b0}}, borrow_in};
    low_diff = {1'b0, st_reg.acc[3:0]} - {1'b0, subtrahend[3:0]} -
               {4'h0, borrow_in};
  end

  ////////////////////////////////////////////////////////////////////////
  // Main next-state logic. Dummy cycle ignores the presented op but still loads prog_addr.

  always_comb
  begin
    st_next.acc = st_reg.acc;
    st_next.tbh = st_reg.tbh;
    st_next.c = st_reg.c;
    st_next.z = st_reg.z;
    st_next.hc = st_reg.hc;
    st_next.ov = st_reg.ov;
    st_next.we = 1'b0;
    st_next.wdata = st_reg.wdata;
    st_next.skip = 1'b0;
    st_next.st = rsd_pkg::RSD_ST_RUN;
    // Program page select: current or all-ones last page; kept in this
    // process so one process owns the whole next-state copy
    st_next.paddr = st_reg.paddr;
    if (op_valid && op_code == rsd_pkg::RSD_OP_TABLE_READ_LAST)
      st_next.paddr = {{PAGE_SEL_W{1'b1}},
                       table_pointer[PAGE_W-1:0]};
    else if (op_valid)
      st_next.paddr = {current_page,
                       table_pointer[PAGE_W-1:0]};
    result = mem_operand;
    exec = op_valid && st_reg.st == rsd_pkg::RSD_ST_RUN;
    if (exec)
    begin
      case (op_code)
        rsd_pkg::RSD_OP_ROTATE_LEFT:
          result = {mem_operand[6:0], mem_operand[`RSD_MSB]};
        rsd_pkg::RSD_OP_ROTATE_RIGHT:
          result = {mem_operand[`RSD_LSB], mem_operand[7:1]};
        rsd_pkg::RSD_OP_ROTATE_LEFT_CARRY:
        begin
          result = {mem_operand[6:0], st_reg.c};
          st_next.c = mem_operand[`RSD_MSB];
        end
        rsd_pkg::RSD_OP_ROTATE_RIGHT_CARRY:
        begin
          result = {st_reg.c, mem_operand[7:1]};
          st_next.c = mem_operand[`RSD_LSB];
        end
        rsd_pkg::RSD_OP_DEDUCT,
        rsd_pkg::RSD_OP_DEDUCT_WITH_BORROW,
        rsd_pkg::RSD_OP_DEDUCT_IMM:
        begin
          result = diff[DATA_W-1:0];
          st_next.c = ~diff[DATA_W];
          st_next.hc = ~low_diff[4];
          st_next.z = (diff[DATA_W-1:0] == '0);
          st_next.ov = (st_reg.acc[7] ^ subtrahend[7]) &
                       (st_reg.acc[7] ^ diff[7]);
        end
        rsd_pkg::RSD_OP_DECREMENT_SKIP_ZERO:
        begin
          result = mem_operand - `RSD_ONE;
          st_next.skip = (result == '0);
        end
        rsd_pkg::RSD_OP_INCREMENT_SKIP_ZERO:
        begin
          result = mem_operand + `RSD_ONE;
          st_next.skip = (result == '0);
        end
        rsd_pkg::RSD_OP_SKIP_BIT_NONZERO:
          st_next.skip = mem_operand[bit_sel];
        rsd_pkg::RSD_OP_SKIP_BIT_ZERO:
          st_next.skip = ~mem_operand[bit_sel];
        rsd_pkg::RSD_OP_SKIP_ON_ZERO,
        rsd_pkg::RSD_OP_SKIP_ZERO_COPY_ACC:
          st_next.skip = (mem_operand == '0);
        rsd_pkg::RSD_OP_SET_BYTE:
          result = `RSD_ALL_ONES;
        rsd_pkg::RSD_OP_SET_BIT:
          result = mem_operand | (`RSD_ONE << bit_sel);
        rsd_pkg::RSD_OP_NIBBLE_EXCHANGE:
          result = {mem_operand[3:0], mem_operand[7:4]};
        rsd_pkg::RSD_OP_TABLE_READ_CURRENT,
        rsd_pkg::RSD_OP_TABLE_READ_LAST:
        begin
          result = prog_rdata[DATA_W-1:0];
          st_next.tbh = prog_rdata[WORD_W-1:DATA_W];
        end
        rsd_pkg::RSD_OP_EXCLUSIVE_OR:
        begin
          result = st_reg.acc ^ mem_operand;
          st_next.z = (result == '0);
        end
        rsd_pkg::RSD_OP_EXCLUSIVE_OR_IMM:
        begin
          result = st_reg.acc ^ imm_value;
          st_next.z = (result == '0);
        end
        default:
          result = mem_operand;
      endcase
      // Destination: pure tests and copy-skip never write memory
      case (op_code)
        rsd_pkg::RSD_OP_NONE,
        rsd_pkg::RSD_OP_SKIP_BIT_NONZERO,
        rsd_pkg::RSD_OP_SKIP_BIT_ZERO,
        rsd_pkg::RSD_OP_SKIP_ON_ZERO:
          st_next.we = 1'b0;
        rsd_pkg::RSD_OP_SKIP_ZERO_COPY_ACC:
          st_next.acc = mem_operand;
        rsd_pkg::RSD_OP_DEDUCT_IMM,
        rsd_pkg::RSD_OP_EXCLUSIVE_OR_IMM:
          st_next.acc = result;
        rsd_pkg::RSD_OP_SET_BYTE,
        rsd_pkg::RSD_OP_SET_BIT,
        rsd_pkg::RSD_OP_TABLE_READ_CURRENT,
        rsd_pkg::RSD_OP_TABLE_READ_LAST:
        begin
          st_next.we = 1'b1;
          st_next.wdata = result;
        end
        default:
          if (to_acc)
            st_next.acc = result;
          else
          begin
            st_next.we = 1'b1;
            st_next.wdata = result;
          end
      endcase
      // Taken skip: next fetched word becomes a dummy
      if (st_next.skip)
        st_next.st = rsd_pkg::RSD_ST_DUMMY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.acc <= `RSD_ACC_RST;
      st_reg.st <= rsd_pkg::RSD_ST_RUN;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from flops
  assign acc = st_reg.acc;
  assign table_high_latch = st_reg.tbh;
  assign carry_flag = st_reg.c;
  assign zero_flag = st_reg.z;
  assign half_carry_flag = st_reg.hc;
  assign overflow_flag = st_reg.ov;
  assign mem_we = st_reg.we;
  assign mem_wdata = st_reg.wdata;
  assign skip_taken = st_reg.skip;
  assign dummy_cycle = st_reg.st == rsd_pkg::RSD_ST_DUMMY;
  assign prog_addr = st_reg.paddr;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_left_carry_out: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_ROTATE_LEFT_CARRY
    |=> carry_flag == $past(mem_operand[7]))
    else $error("rotate left carry lost bit 7");

  a_right_carry_out: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_ROTATE_RIGHT_CARRY
    |=> carry_flag == $past(mem_operand[0]))
    else $error("rotate right carry lost bit 0");

  a_rotate_no_flags: assert property (
    op_valid && !dummy_cycle && op_code == rsd_pkg::RSD_OP_ROTATE_RIGHT
    |=> $stable(carry_flag) && $stable(zero_flag))
    else $error("plain rotate changed a flag");

  a_left_rotate_value: assert property (
    op_valid && !dummy_cycle && to_acc &&
    op_code == rsd_pkg::RSD_OP_ROTATE_LEFT
    |=> acc == {$past(mem_operand[6:0]), $past(mem_operand[7])}
        && $stable(carry_flag))
    else $error("plain rotate left wrong");

  a_acc_no_write: assert property (
    op_valid && !dummy_cycle && to_acc &&
    op_code == rsd_pkg::RSD_OP_NIBBLE_EXCHANGE
    |=> !mem_we && acc == {$past(mem_operand[3:0]),
                           $past(mem_operand[7:4])})
    else $error("accumulator swap touched memory");

  a_borrow_sub_acc: assert property (
    op_valid && !dummy_cycle && to_acc &&
    op_code == rsd_pkg::RSD_OP_DEDUCT_WITH_BORROW
    |=> acc == $past(acc) - $past(mem_operand)
               - {7'h00, !$past(carry_flag)})
    else $error("deduct with borrow wrong");

  a_sub_carry: assert property (
    op_valid && !dummy_cycle && op_code == rsd_pkg::RSD_OP_DEDUCT
    |=> carry_flag == ($past(acc) >= $past(mem_operand)))
    else $error("subtract carry not inverted borrow");

  a_imm_sub_acc: assert property (
    op_valid && !dummy_cycle && op_code == rsd_pkg::RSD_OP_DEDUCT_IMM
    |=> acc == $past(acc) - $past(imm_value) && !mem_we)
    else $error("immediate deduct wrong");

  a_skip_dummy: assert property (
    skip_taken |-> dummy_cycle ##1 !dummy_cycle)
    else $error("taken skip without single dummy");

  a_decrement_skip: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_DECREMENT_SKIP_ZERO
    |=> skip_taken == ($past(mem_operand) == 8'h01)
        && $stable(carry_flag))
    else $error("decrement skip wrong");

  a_increment_skip: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_INCREMENT_SKIP_ZERO
    |=> skip_taken == ($past(mem_operand) == 8'hff)
        && $stable(carry_flag) && $stable(zero_flag))
    else $error("increment skip wrong");

  a_acc_decrement: assert property (
    op_valid && !dummy_cycle && to_acc &&
    op_code == rsd_pkg::RSD_OP_DECREMENT_SKIP_ZERO
    |=> acc == $past(mem_operand) - `RSD_ONE && !mem_we
        && skip_taken == (acc == '0))
    else $error("accumulator decrement skip wrong");

  a_bit_set_skip: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_SKIP_BIT_NONZERO
    |=> skip_taken == $past(mem_operand[bit_sel]) && !mem_we)
    else $error("bit nonzero skip wrong");

  a_bit_clear_skip: assert property (
    op_valid && !dummy_cycle && op_code == rsd_pkg::RSD_OP_SKIP_BIT_ZERO
    |=> skip_taken == !$past(mem_operand[bit_sel]) && !mem_we)
    else $error("bit zero skip wrong");

  a_copy_skip_acc: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_SKIP_ZERO_COPY_ACC
    |=> acc == $past(mem_operand) && !mem_we
        && skip_taken == ($past(mem_operand) == '0))
    else $error("copy skip wrong");

  a_table_split: assert property (
    op_valid && !dummy_cycle &&
    op_code == rsd_pkg::RSD_OP_TABLE_READ_CURRENT
    |=> mem_we && mem_wdata == $past(prog_rdata[7:0])
        && table_high_latch == $past(prog_rdata[15:8]))
    else $error("table read halves wrong");

  a_xor_zero: assert property (
    op_valid && !dummy_cycle && op_code == rsd_pkg::RSD_OP_EXCLUSIVE_OR
    |=> zero_flag == ($past(acc) == $past(mem_operand))
        && $stable(carry_flag))
    else $error("xor zero flag wrong");

  a_dummy_ignored: assert property (
    dummy_cycle |=> !skip_taken && !mem_we && $stable(acc))
    else $error("dummy cycle executed an op");

  c_skip_taken: cover property (@(posedge clk_sys) disable iff (!rst_n)
    skip_taken);
  c_sub_negative: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == rsd_pkg::RSD_OP_DEDUCT_WITH_BORROW ##1
    !carry_flag);
  c_table_last: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == rsd_pkg::RSD_OP_TABLE_READ_LAST ##1 mem_we);

endmodule // rsd_datapath

`default_nettype wire

// ==== rtl/rsd_regs.svh ====
// Constants for the rotate/subtract/skip datapath.
// Assumes inclusion by the datapath module only; rsd_pkg.sv does not include it.
`ifndef RSD_REGS_SVH
`define RSD_REGS_SVH

// Byte geometry
`define RSD_MSB 3'h7
`define RSD_LSB 3'h0
// Values written by the set forms and reset values
`define RSD_ALL_ONES 8'hff
`define RSD_ACC_RST 8'h00
`define RSD_ONE 8'h01
// Cycles a taken skip costs (execute plus one dummy)
`define RSD_SKIP_CYCLES 2

`endif

// ==== rtl/rsd_pkg.sv ====
// Types for the rotate/subtract/skip datapath.
// Assumes the constants header sits next to it.
package rsd_pkg;

  // Operation selected by the sequencer
  typedef enum logic [4:0] {
    RSD_OP_NONE,
    RSD_OP_ROTATE_LEFT,
    RSD_OP_ROTATE_LEFT_CARRY,
    RSD_OP_ROTATE_RIGHT,
    RSD_OP_ROTATE_RIGHT_CARRY,
    RSD_OP_DEDUCT,
    RSD_OP_DEDUCT_WITH_BORROW,
    RSD_OP_DEDUCT_IMM,
    RSD_OP_DECREMENT_SKIP_ZERO,
    RSD_OP_INCREMENT_SKIP_ZERO,
    RSD_OP_SKIP_BIT_NONZERO,
    RSD_OP_SKIP_BIT_ZERO,
    RSD_OP_SKIP_ON_ZERO,
    RSD_OP_SKIP_ZERO_COPY_ACC,
    RSD_OP_SET_BYTE,
    RSD_OP_SET_BIT,
    RSD_OP_NIBBLE_EXCHANGE,
    RSD_OP_TABLE_READ_CURRENT,
    RSD_OP_TABLE_READ_LAST,
    RSD_OP_EXCLUSIVE_OR,
    RSD_OP_EXCLUSIVE_OR_IMM
  } rsd_op_t;

  typedef enum logic [0:0] {
    RSD_ST_RUN,
    RSD_ST_DUMMY
  } rsd_state_t;

endpackage

// ==== test/rsd_prog_model.sv ====
// Program memory model seen by the datapath during table reads.
// Assumes the bench drives the word address; answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module rsd_prog_model (
  input wire logic [15:0] word_addr,
  output logic [15:0] word_data
);
  // High half depends on the page, so a wrong page shows up
  assign word_data = {word_addr[15:8] ^ ~word_addr[7:0],
                      word_addr[7:0] ^ 8'h5a};
endmodule // rsd_prog_model
`default_nettype wire

// ==== test/mcu_rotate_sub_skip_datapath_test.sv ====
// Self-checking random bench for the rotate/subtract/skip datapath.
// Assumes the program model answers combinationally to word_addr.
`timescale 1ns/1ps
`default_nettype none
module mcu_rotate_sub_skip_datapath_test;
  typedef struct packed {
    logic [7:0] acc, tbh, wd;
    logic [15:0] addr;
    logic c, z, hc, ov, we, skip, tbl;
  } rsd_exp_t;
  logic clk_sys, rst_n, op_valid, to_acc, s_v, s_ta;
  rsd_pkg::rsd_op_t op_code, s_op;
  logic [2:0] bit_sel, s_bs;
  logic [7:0] mem_operand, imm_value, table_pointer, current_page;
  logic [7:0] s_m, s_imm, s_tp, s_pg, mem_wdata, acc, table_high_latch;
  logic [15:0] prog_rdata, prog_addr, word_addr, s_addr;
  logic mem_we, carry_flag, zero_flag, half_carry_flag, overflow_flag;
  logic skip_taken, dummy_cycle;
  int failures, n_checks;
  rsd_exp_t prev, cur;

  rsd_datapath dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .to_acc(to_acc), .bit_sel(bit_sel),
    .mem_operand(mem_operand), .imm_value(imm_value),
    .table_pointer(table_pointer), .current_page(current_page),
    .prog_rdata(prog_rdata), .prog_addr(prog_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .acc(acc), .table_high_latch(table_high_latch),
    .carry_flag(carry_flag), .zero_flag(zero_flag),
    .half_carry_flag(half_carry_flag), .overflow_flag(overflow_flag),
    .skip_taken(skip_taken), .dummy_cycle(dummy_cycle));
  rsd_prog_model prog_u (.word_addr(word_addr), .word_data(prog_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Bench copy of the program contents
  function automatic logic [15:0] rom_word(input logic [15:0] a);
    return {a[15:8] ^ ~a[7:0], a[7:0] ^ 8'h5a};
  endfunction

  task automatic chk(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    n_checks++;
    if (exp !== got)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // First 42 ops walk every code in both destinations, then random
  task automatic pick(input int i);
    s_op = rsd_pkg::rsd_op_t'((i < 42) ? i / 2 : $urandom_range(20));
    s_ta = (i < 42) ? i[0] : 1'($urandom_range(1));
    s_v = (i < 42) || ($urandom_range(7) != 0);
    s_bs = 3'($urandom_range(7));
    // Boundary operands are favoured: zero, one, all ones, sign bit
    case ($urandom_range(5))
      0: s_m = 8'h00;
      1: s_m = 8'h01;
      2: s_m = 8'hff;
      3: s_m = 8'h80;
      default: s_m = 8'($urandom);
    endcase
    s_imm = 8'($urandom);
    s_tp = 8'($urandom);
    s_pg = 8'($urandom);
    s_addr = {(s_op == rsd_pkg::RSD_OP_TABLE_READ_LAST) ? 8'hff : s_pg, s_tp};
  endtask

  // Expected state after the staged op; d: 0 none, 1 acc, 2 memory
  task automatic model();
    logic [8:0] f;
    logic [4:0] h;
    logic [7:0] b, r;
    logic bw, sub;
    logic [1:0] d;
    cur = prev;
    cur.we = 1'b0;
    cur.skip = 1'b0;
    cur.tbl = 1'b0;
    sub = 1'b0;
    bw = 1'b0;
    b = s_m;
    r = s_m;
    d = s_ta ? 2'h1 : 2'h2;
    // Op under a dummy cycle is the skipped one
    if (!s_v || prev.skip)
      return;
    case (s_op)
      rsd_pkg::RSD_OP_ROTATE_LEFT: r = {s_m[6:0], s_m[7]};
      rsd_pkg::RSD_OP_ROTATE_LEFT_CARRY: r = {s_m[6:0], prev.c};
      rsd_pkg::RSD_OP_ROTATE_RIGHT: r = {s_m[0], s_m[7:1]};
      rsd_pkg::RSD_OP_ROTATE_RIGHT_CARRY: r = {prev.c, s_m[7:1]};
      rsd_pkg::RSD_OP_DEDUCT: sub = 1'b1;
      rsd_pkg::RSD_OP_DEDUCT_WITH_BORROW:
        {sub, bw} = {1'b1, ~prev.c};
      rsd_pkg::RSD_OP_DEDUCT_IMM:
        {sub, b, d} = {1'b1, s_imm, 2'h1};
      rsd_pkg::RSD_OP_DECREMENT_SKIP_ZERO: r = s_m - 8'h01;
      rsd_pkg::RSD_OP_INCREMENT_SKIP_ZERO: r = s_m + 8'h01;
      rsd_pkg::RSD_OP_SKIP_BIT_NONZERO:
        {cur.skip, d} = {s_m[s_bs], 2'h0};
      rsd_pkg::RSD_OP_SKIP_BIT_ZERO:
        {cur.skip, d} = {~s_m[s_bs], 2'h0};
      rsd_pkg::RSD_OP_SKIP_ON_ZERO: d = 2'h0;
      rsd_pkg::RSD_OP_SKIP_ZERO_COPY_ACC: d = 2'h1;
      rsd_pkg::RSD_OP_SET_BYTE: {r, d} = {8'hff, 2'h2};
      rsd_pkg::RSD_OP_SET_BIT:
        {r, d} = {s_m | (8'h01 << s_bs), 2'h2};
      rsd_pkg::RSD_OP_NIBBLE_EXCHANGE: r = {s_m[3:0], s_m[7:4]};
      rsd_pkg::RSD_OP_EXCLUSIVE_OR: r = prev.acc ^ s_m;
      rsd_pkg::RSD_OP_EXCLUSIVE_OR_IMM:
        {r, d} = {prev.acc ^ s_imm, 2'h1};
      rsd_pkg::RSD_OP_NONE: d = 2'h0;
      // Low byte of the program word goes to memory, high to the latch
      default: {cur.tbh, r, cur.tbl, cur.addr, d} =
        {rom_word(s_addr), 1'b1, s_addr, 2'h2};
    endcase
    if (s_op == rsd_pkg::RSD_OP_ROTATE_LEFT_CARRY)
      cur.c = s_m[7];
    if (s_op == rsd_pkg::RSD_OP_ROTATE_RIGHT_CARRY)
      cur.c = s_m[0];
    // Carry reads as no borrow; half carry as no borrow out of bit 3
    if (sub)
    begin
      f = {1'b0, prev.acc} - {1'b0, b} - {8'h00, bw};
      h = {1'b0, prev.acc[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
      r = f[7:0];
      cur.c = ~f[8];
      cur.hc = ~h[4];
      cur.ov = (prev.acc[7] ^ b[7]) & (prev.acc[7] ^ r[7]);
    end
    if (sub || s_op inside {rsd_pkg::RSD_OP_EXCLUSIVE_OR,
        rsd_pkg::RSD_OP_EXCLUSIVE_OR_IMM})
      cur.z = (r == 8'h00);
    if (s_op inside {rsd_pkg::RSD_OP_DECREMENT_SKIP_ZERO,
        rsd_pkg::RSD_OP_INCREMENT_SKIP_ZERO, rsd_pkg::RSD_OP_SKIP_ON_ZERO,
        rsd_pkg::RSD_OP_SKIP_ZERO_COPY_ACC})
      cur.skip = (r == 8'h00);
    if (d == 2'h1)
      cur.acc = r;
    cur.we = (d == 2'h2);
    if (d == 2'h2)
      cur.wd = r;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: drive at rising edge, check at the falling edge after
  initial
  begin
    failures = 0;
    n_checks = 0;
    rst_n = 1'b0;
    op_code = rsd_pkg::RSD_OP_NONE;
    {op_valid, to_acc, bit_sel, mem_operand, imm_value} = '0;
    {table_pointer, current_page, word_addr} = '0;
    prev = '0;
    void'($urandom(32'h0f81aedb));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 2000; i++)
    begin
      pick(i);
      model();
      @(posedge clk_sys);
      op_valid <= s_v;
      op_code <= s_op;
      to_acc <= s_ta;
      bit_sel <= s_bs;
      mem_operand <= s_m;
      imm_value <= s_imm;
      table_pointer <= s_tp;
      current_page <= s_pg;
      word_addr <= s_addr;
      @(negedge clk_sys);
      chk("acc", 16'(prev.acc), 16'(acc));
      chk("carry", 16'(prev.c), 16'(carry_flag));
      chk("zero", 16'(prev.z), 16'(zero_flag));
      chk("half", 16'(prev.hc), 16'(half_carry_flag));
      chk("ovf", 16'(prev.ov), 16'(overflow_flag));
      chk("mem_we", 16'(prev.we), 16'(mem_we));
      if (prev.we)
        chk("wdata", 16'(prev.wd), 16'(mem_wdata));
      chk("skip", 16'(prev.skip), 16'(skip_taken));
      chk("dummy", 16'(prev.skip), 16'(dummy_cycle));
      chk("latch", 16'(prev.tbh), 16'(table_high_latch));
      if (prev.tbl)
        chk("prog_addr", prev.addr, prog_addr);
      prev = cur;
    end
    final_report();
  end

  // Watchdog well past the expected 2020 cycles
  initial
  begin
    #(25 * 4000);
    failures++;
    final_report();
  end
endmodule // mcu_rotate_sub_skip_datapath_test
`default_nettype wire
